// >>> rtl/fsp_defines.svh
// constants for the flash self-programming lock and fuse access block
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_ADDR_CTRL      2'h0
`define FSP_ADDR_LOCKS     2'h1
`define FSP_ADDR_FUSE_LO   2'h2
`define FSP_ADDR_FUSE_HI   2'h3
`define FSP_BIT_EN         0
`define FSP_BIT_ERASE      1
`define FSP_BIT_WRITE      2
`define FSP_BIT_LOCKSET    3
`define FSP_BIT_RWWEN      4
`define FSP_BIT_SIGNATURE_READ_CMD      5
`define FSP_BIT_BUSY       6
`define FSP_CMD_LOCK       5'h09
`define FSP_CMD_ERASE      5'h03
`define FSP_CMD_WRITE      5'h05
`define FSP_CMD_RWW        5'h11
`define FSP_CMD_FILL       5'h01
`define FSP_SIG_ARM        6'h21
`define FSP_LOAD_WIN       3'h3
`define FSP_STORE_WIN      3'h4
`define FSP_PTR_FUSE_LO    16'h0000
`define FSP_PTR_LOCK       16'h0001
`define FSP_PTR_EXT_FUSE   16'h0002
`define FSP_PTR_FUSE_HI    16'h0003
`define FSP_PTR_SIG0       16'h0000
`define FSP_PTR_CAL        16'h0001
`define FSP_PTR_SIG1       16'h0002
`define FSP_PTR_SIG2       16'h0004
`define FSP_EXT_MASK       8'h07
`define FSP_BOOT_MASK      8'h3C
`define FSP_LOCK_RESET     8'hFF
`define FSP_PROG_MIN_US    3700
`define FSP_CLK_MHZ        50
`endif

// >>> rtl/fsp_pkg.sv
// types for the flash self-programming lock and fuse access block
package fsp_pkg;
  typedef enum logic [1:0]
  {
    FSP_IDLE  = 2'b00,
    FSP_ARMED = 2'b01,
    FSP_PROG  = 2'b10
  } fsp_state_t;
  typedef enum logic [1:0]
  {
    FSP_OP_NONE  = 2'b00,
    FSP_OP_LOCK  = 2'b01,
    FSP_OP_ERASE = 2'b10,
    FSP_OP_WRITE = 2'b11
  } fsp_op_t;
endpackage

// >>> rtl/fsp_sync.sv
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module fsp_sync
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// >>> rtl/fsp_top.sv
// flash self-programming control: rww blocking, lock bits, fuse reads
//
// Functional notes
// - block rww section reads during erase/write; rst drops the block while the op runs on
// - busy flag high while rww section busy
// - lock pattern then store within four cycles
// - program boot locks where data bits zero
// - only boot lock bits writable this way
// - whole flash readable while locks programmed
// - eeprom write blocks programming and fuse reads
// - lock arm, pointer 1, load returns locks
// - lock arm clears on read or timeouts
// - cleared arm means ordinary program read
// - fuse arm pointer 0 returns low fuse
// - fuse arm pointer 3 returns high fuse
// - pointer 2 returns extended fuse, three bits
// - programmed reads zero, unprogrammed reads one
// - signature arm, load returns selected row byte
// - signature bytes at pointers 0, 2, 4
// - pointer 1 returns calibration byte
// - signature arm clears on read or timeout
// - flash write finishes even across reset
// - undefined low five bit patterns ignored
// - programming lasts 3.7 to 4.5 ms
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_top
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = `FSP_PROG_MIN_US * `FSP_CLK_MHZ,
  parameter logic [7:0] SIG_BYTE0 = 8'h5A,  // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'hA5,  // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C,  // arbitrary value
  parameter logic [7:0] CAL_BYTE  = 8'h80,
  parameter logic [7:0] FUSE_LO   = 8'hFF,
  parameter logic [7:0] FUSE_HI   = 8'hFF,
  parameter logic [7:0] FUSE_EXT  = 8'hFF
)
(
  // clock and resets; por_rst clears the flash timer, rst does not
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        por_rst,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // core instruction side
  input  wire logic        store_program_instr,
  input  wire logic        load_program_instr,
  input  wire logic [15:0] flash_address_pointer,
  input  wire logic [7:0]  core_data_reg_zero,
  input  wire logic        fetch_in_rww,
  // eeprom status pin
  input  wire logic        eeprom_write_active,
  // answers
  output logic      [7:0]  load_data,
  output logic             load_special,
  output logic             rww_read_block,
  output logic             flash_op_active
);
  ////////////////////////////////////////////////////////////////////////
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  fsp_state_t     state_reg;
  fsp_op_t        op_reg;
  logic [2:0]     win_reg;
  logic [4:0]     cmd_reg;
  logic           sig_reg;
  logic           busy_reg;
  logic [CW-1:0]  tmr_reg;
  logic [7:0]     lock_reg;
  logic [7:0]     lock_pend_reg;
  logic           done_pulse;
  logic           ee_busy;

  fsp_sync u_ee_sync
  (
    .clock (clock),
    .rst   (rst),
    .din   (eeprom_write_active),
    .dout  (ee_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  logic       ctrl_wr;
  logic [4:0] wcmd;
  logic       cmd_ok;
  logic       sig_ok;
  logic       armed;
  logic       ld_hit;
  logic       st_hit;

  assign ctrl_wr = reg_wr && reg_addr == `FSP_ADDR_CTRL;
  assign wcmd    = reg_wdata[4:0];
  assign sig_ok  = reg_wdata[5:0] == `FSP_SIG_ARM;
  assign cmd_ok  = wcmd == `FSP_CMD_LOCK  || wcmd == `FSP_CMD_ERASE ||
                   wcmd == `FSP_CMD_WRITE || wcmd == `FSP_CMD_RWW   ||
                   wcmd == `FSP_CMD_FILL  || sig_ok;
  assign armed   = state_reg == FSP_ARMED;
  assign ld_hit  = armed && load_program_instr && win_reg < `FSP_LOAD_WIN &&
                   (cmd_reg == `FSP_CMD_LOCK || sig_reg);
  assign st_hit  = armed && store_program_instr && !sig_reg &&
                   win_reg < `FSP_STORE_WIN;

  // arm, timeouts and programming sequence
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= FSP_IDLE;
      win_reg   <= 3'h0;
      cmd_reg   <= 5'h00;
      sig_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        FSP_IDLE:
        begin
          // eeprom write blocks arming entirely
          if (ctrl_wr && cmd_ok && !ee_busy && op_reg == FSP_OP_NONE)
          begin
            state_reg <= FSP_ARMED;
            win_reg   <= 3'h0;
            cmd_reg   <= wcmd;
            sig_reg   <= sig_ok;
          end
        end
        FSP_ARMED:
        begin
          win_reg <= win_reg + 3'h1;
          if (ld_hit)
          begin
            state_reg <= FSP_IDLE;
            cmd_reg   <= 5'h00;
            sig_reg   <= 1'b0;
          end
          else if (st_hit && (cmd_reg == `FSP_CMD_LOCK ||
                   cmd_reg == `FSP_CMD_ERASE || cmd_reg == `FSP_CMD_WRITE))
            state_reg <= FSP_PROG;
          else if (st_hit)
          begin
            state_reg <= FSP_IDLE;
            cmd_reg   <= 5'h00;
          end
          else if ((sig_reg && win_reg >= `FSP_LOAD_WIN - 3'h1) ||
                   win_reg >= `FSP_STORE_WIN - 3'h1)
          begin
            state_reg <= FSP_IDLE;
            cmd_reg   <= 5'h00;
            sig_reg   <= 1'b0;
          end
        end
        FSP_PROG:
        begin
          // enable bit stays up until the timer finishes
          if (done_pulse)
          begin
            state_reg <= FSP_IDLE;
            cmd_reg   <= 5'h00;
          end
        end
        default:
          state_reg <= FSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash timer lives on power-on reset only so a running write survives
  always_ff @(posedge clock or posedge por_rst)
  begin
    if (por_rst)
    begin
      op_reg        <= FSP_OP_NONE;
      tmr_reg       <= '0;
      lock_pend_reg <= 8'hFF;
    end
    else if (op_reg != FSP_OP_NONE)
    begin
      if (tmr_reg == PROG_LAST)
        op_reg <= FSP_OP_NONE;
      tmr_reg <= tmr_reg + CW'(1);
    end
    else if (st_hit)
    begin
      tmr_reg       <= '0;
      lock_pend_reg <= core_data_reg_zero;
      case (cmd_reg)
        `FSP_CMD_LOCK:  op_reg <= FSP_OP_LOCK;
        `FSP_CMD_ERASE: op_reg <= FSP_OP_ERASE;
        `FSP_CMD_WRITE: op_reg <= FSP_OP_WRITE;
        default:        op_reg <= FSP_OP_NONE;
      endcase
    end
  end

  assign done_pulse = op_reg != FSP_OP_NONE && tmr_reg == PROG_LAST;

  // nonvolatile lock image; only boot lock bits may go to zero
  always_ff @(posedge clock or posedge por_rst)
  begin
    if (por_rst)
      lock_reg <= `FSP_LOCK_RESET;
    else if (done_pulse && op_reg == FSP_OP_LOCK)
      lock_reg <= lock_reg & (lock_pend_reg | ~`FSP_BOOT_MASK);
  end

  // rww busy set by erase/write start, cleared by the enable command
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      busy_reg <= 1'b0;
    else if (st_hit && (cmd_reg == `FSP_CMD_ERASE ||
             cmd_reg == `FSP_CMD_WRITE))
      busy_reg <= 1'b1;
    else if (st_hit && cmd_reg == `FSP_CMD_RWW &&
             op_reg == FSP_OP_NONE)
      busy_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] spec_val;

  always_comb
  begin
    spec_val = 8'hFF;
    if (sig_reg)
    begin
      case (flash_address_pointer)
        `FSP_PTR_SIG0: spec_val = SIG_BYTE0;
        `FSP_PTR_SIG1: spec_val = SIG_BYTE1;
        `FSP_PTR_SIG2: spec_val = SIG_BYTE2;
        `FSP_PTR_CAL:  spec_val = CAL_BYTE;
        default:       spec_val = 8'hFF;
      endcase
    end
    else
    begin
      // programmed bits read zero straight from the stored images
      case (flash_address_pointer)
        `FSP_PTR_LOCK:     spec_val = lock_reg;
        `FSP_PTR_FUSE_LO:  spec_val = FUSE_LO;
        `FSP_PTR_FUSE_HI:  spec_val = FUSE_HI;
        `FSP_PTR_EXT_FUSE: spec_val = FUSE_EXT | ~`FSP_EXT_MASK;
        default:           spec_val = 8'hFF;
      endcase
    end
  end

  // load answer; load_special low means core does an ordinary read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      load_data    <= 8'hFF;
      load_special <= 1'b0;
    end
    else
    begin
      load_special <= ld_hit && !(ee_busy && !sig_reg);
      load_data    <= ld_hit ? spec_val : 8'hFF;
    end
  end

  // lock writes leave the rww section readable
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rww_read_block  <= 1'b0;
      flash_op_active <= 1'b0;
    end
    else
    begin
      rww_read_block  <= fetch_in_rww && busy_reg;
      flash_op_active <= op_reg != FSP_OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `FSP_ADDR_CTRL:    reg_rdata <= {1'b0, busy_reg, sig_reg, cmd_reg};
        `FSP_ADDR_LOCKS:   reg_rdata <= lock_reg;
        `FSP_ADDR_FUSE_LO: reg_rdata <= FUSE_LO;
        `FSP_ADDR_FUSE_HI: reg_rdata <= FUSE_HI;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> testbench/fsp_core_model.sv
// behavioural core issuing store and load program instructions
`timescale 1ns/1ps
module fsp_core_model
(
  // clock
  input  wire logic   clock,
  // instruction side
  output logic        store_program_instr,
  output logic        load_program_instr,
  output logic [15:0] flash_address_pointer,
  output logic [7:0]  core_data_reg_zero
);
  initial
  begin
    store_program_instr = 1'b0;
    load_program_instr = 1'b0;
    flash_address_pointer = 16'h0000;
    core_data_reg_zero = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // entered on an edge; returns on the edge that takes the instruction
  task automatic store(input logic [7:0] d);
    core_data_reg_zero <= d;
    flash_address_pointer <= 16'h0001;
    store_program_instr <= 1'b1;
    @(posedge clock);
    store_program_instr <= 1'b0;
  endtask
  task automatic load(input logic [15:0] p);
    flash_address_pointer <= p;
    load_program_instr <= 1'b1;
    @(posedge clock);
    load_program_instr <= 1'b0;
  endtask
endmodule

// >>> testbench/fsp_top_sva.sv
// assertions on the ports of the flash self-programming block
`timescale 1ns/1ps
module fsp_top_sva
#(
  parameter int PROG_CYCLES = 20
)
(
  // watched ports
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        por_rst,
  input wire logic [1:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        store_program_instr,
  input wire logic        load_program_instr,
  input wire logic [15:0] flash_address_pointer,
  input wire logic        fetch_in_rww,
  input wire logic        eeprom_write_active,
  input wire logic        load_special,
  input wire logic        rww_read_block,
  input wire logic        flash_op_active
);
  int op_cnt;
  logic rst_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // counts through rst, as the flash op itself does
  always_ff @(posedge clock or posedge por_rst)
  begin
    if (por_rst)
    begin
      op_cnt <= 0;
      rst_d  <= 1'b0;
    end
    else
    begin
      // rst hides the output for two edges while the op runs on
      rst_d  <= rst;
      op_cnt <= (flash_op_active || ((rst || rst_d) && op_cnt != 0)) ?
                op_cnt + 1 : 0;
    end
  end
  sequence s_cmd(logic [7:0] c);
    reg_wr && reg_addr == 2'h0 && reg_wdata == c && !eeprom_write_active
      && !flash_op_active;
  endsequence
  sequence s_q;
    !load_program_instr && !store_program_instr;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_RWW_CAUSE: assert property
    (rww_read_block |-> $past(fetch_in_rww)) else $error("rww block");
  AST_SPECIAL_CAUSE: assert property
    (load_special |-> $past(load_program_instr)) else $error("stray answer");
  AST_LOCK_READ: assert property
    (s_cmd(8'h09) ##1 (load_program_instr && flash_address_pointer ==
      16'h0001) |=> load_special) else $error("lock read missing");
  AST_LOCK_CLEAR: assert property
    (s_cmd(8'h09) ##1 load_program_instr ##1 s_q ##1 load_program_instr
      |=> !load_special) else $error("lock arm kept");
  AST_LOCK_EXPIRE: assert property
    (s_cmd(8'h09) ##1 s_q[*3] ##1 load_program_instr |=> !load_special)
    else $error("lock arm not expired");
  AST_SIG_EXPIRE: assert property
    (s_cmd(8'h21) ##1 s_q[*3] ##1 load_program_instr |=> !load_special)
    else $error("signature arm not expired");
  AST_BAD_CMD: assert property
    (s_cmd(8'h07) ##1 load_program_instr |=> !load_special)
    else $error("undefined command acted");
  AST_OP_START: assert property
    (s_cmd(8'h09) ##1 store_program_instr |-> ##[1:2] flash_op_active)
    else $error("lock write not started");
  AST_OP_LEN: assert property
    ($fell(flash_op_active) |-> op_cnt >= PROG_CYCLES &&
      op_cnt <= PROG_CYCLES * 6 / 5 + 2) else $error("op length");
endmodule
bind fsp_top fsp_top_sva #(.PROG_CYCLES(PROG_CYCLES)) i_fsp_top_sva
(
  .clock, .rst, .por_rst, .reg_addr, .reg_wdata, .reg_wr,
  .store_program_instr, .load_program_instr, .flash_address_pointer,
  .fetch_in_rww, .eeprom_write_active, .load_special, .rww_read_block,
  .flash_op_active
);

// >>> testbench/fsp_top_tb.sv
// self-checking bench for the flash self-programming block
`timescale 1ns/1ps
module fsp_top_tb;
  logic        clock, rst, por_rst, reg_wr, reg_rd, fetch_in_rww;
  logic        eeprom_write_active, store_program_instr;
  logic        load_program_instr, load_special, rww_read_block;
  logic        flash_op_active;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, core_data_reg_zero, load_data;
  logic [15:0] flash_address_pointer;
  int          num_errors = 0;
  int          n_compared = 0;
  // signature and calibration values are arbitrary
  logic [15:0] sp [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0003};
  logic [7:0]  sv [5] = '{8'h12, 8'h6B, 8'h34, 8'h56, 8'hFF};
  logic [15:0] fp [3] = '{16'h0000, 16'h0003, 16'h0002};
  logic [7:0]  fv [3] = '{8'hA6, 8'h59, 8'h05};
  logic [7:0]  fm [3] = '{8'hFF, 8'hFF, 8'h07};
  fsp_top #(.PROG_CYCLES(20), .SIG_BYTE0(8'h12), .SIG_BYTE1(8'h34),
    .SIG_BYTE2(8'h56), .CAL_BYTE(8'h6B), .FUSE_LO(8'hA6),
    .FUSE_HI(8'h59), .FUSE_EXT(8'hF5)) i_fsp_top
  (
    .clock, .rst, .por_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .store_program_instr, .load_program_instr,
    .flash_address_pointer, .core_data_reg_zero, .fetch_in_rww,
    .eeprom_write_active, .load_data, .load_special, .rww_read_block,
    .flash_op_active
  );
  fsp_core_model i_fsp_core_model
  (
    .clock, .store_program_instr, .load_program_instr,
    .flash_address_pointer, .core_data_reg_zero
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // answers stand one cycle, so they are looked at mid-cycle
  task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    cmp(reg_rdata & m, e & m);
    @(posedge clock);
  endtask
  task automatic ld(input logic [15:0] p, input logic s,
    input logic [7:0] e, m);
    i_fsp_core_model.load(p);
    @(negedge clock);
    cmp({7'h00, load_special}, {7'h00, s});
    if (s)
      cmp(load_data & m, e & m);
    @(posedge clock);
  endtask
  task automatic lv(input logic [1:0] e);
    @(negedge clock);
    cmp({6'h00, rww_read_block, flash_op_active}, {6'h00, e});
    @(posedge clock);
  endtask
  task automatic wait_op;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 100 && flash_op_active !== 1'b0; i++)
      @(posedge clock);
    @(negedge clock);
    cmp({7'h00, flash_op_active}, 8'h00);
    @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial
  begin
    {rst, por_rst, reg_wr, reg_rd} = 4'h3 << 2;
    {fetch_in_rww, eeprom_write_active, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clock);
    {rst, por_rst} <= 2'b00;
    @(posedge clock);
    rd(2'h0, 8'h00, 8'hFF);
    rd(2'h1, 8'hFF, 8'hFF);
    wr(2'h0, 8'h09);
    ld(16'h0001, 1'b1, 8'hFF, 8'hFF);
    ld(16'h0001, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(2'h0, 8'h09);
      ld(fp[i], 1'b1, fv[i], fm[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr(2'h0, 8'h21);
      ld(sp[i], 1'b1, sv[i], 8'hFF);
    end
    for (int k = 2; k < 4; k++)
    begin
      wr(2'h0, 8'h09);
      repeat (k) @(posedge clock);
      ld(16'h0001, k == 2, 8'hFF, 8'hFF);
    end
    wr(2'h0, 8'h21);
    repeat (3) @(posedge clock);
    ld(16'h0000, 1'b0, 8'h00, 8'h00);
    wr(2'h0, 8'h07);
    ld(16'h0001, 1'b0, 8'h00, 8'h00);
    rd(2'h0, 8'h00, 8'hFF);
    fetch_in_rww <= 1'b1;
    wr(2'h0, 8'h09);
    i_fsp_core_model.store(8'hE8);
    rd(2'h0, 8'h01, 8'h01);
    lv(2'b01);
    wait_op();
    rd(2'h0, 8'h00, 8'h01);
    rd(2'h1, 8'hEB, 8'hFF);
    wr(2'h0, 8'h03);
    i_fsp_core_model.store(8'hFF);
    rd(2'h0, 8'h40, 8'h40);
    lv(2'b11);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    lv(2'b01);
    wait_op();
    wr(2'h0, 8'h05);
    i_fsp_core_model.store(8'hFF);
    wait_op();
    rd(2'h0, 8'h40, 8'h40);
    lv(2'b10);
    wr(2'h0, 8'h11);
    i_fsp_core_model.store(8'hFF);
    rd(2'h0, 8'h00, 8'h40);
    lv(2'b00);
    eeprom_write_active <= 1'b1;
    repeat (3) @(posedge clock);
    wr(2'h0, 8'h09);
    ld(16'h0001, 1'b0, 8'h00, 8'h00);
    wr(2'h0, 8'h03);
    i_fsp_core_model.store(8'hFF);
    lv(2'b00);
    give_verdict();
  end
endmodule
